// file: logic/cfm_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CFM_REGS_SVH
`define CFM_REGS_SVH
`define CFM_CTRL_ADDR    8'h00
`define CFM_STATUS_ADDR  8'h04
`define CFM_STATIC_ADDR  8'h08
`define CFM_VERT_ADDR    8'h0c
`define CFM_FMODE_HI     1
`define CFM_FMODE_LO     0
`define CFM_MMODE_HI     3
`define CFM_MMODE_LO     2
`define CFM_FCTL_BIT     4
`define CFM_PMODE_HI     6
`define CFM_PMODE_LO     5
`define CFM_CTRL_W       7
`define CFM_CTRL_RST     7'h02
`define CFM_PARAM_RST    16'h0000
`define CFM_ST_LOCK      0
`define CFM_ST_FDET      1
`define CFM_ST_FCOMP     2
`define CFM_ST_MOTION    3
`define CFM_LOCK_FIELDS  3'h4
`define CFM_DI_FIELDS    2'h1
`define CFM_DI_LINES     10'h006
`define CFM_DI_PIXELS    7'h5b
`define CFM_FILM_FIELDS  2'h2
`define CFM_FILM_LINES   10'h004
`define CFM_FILM_PIXELS  7'h08
`define CFM_PSF_FIELDS   2'h1
`define CFM_PSF_LINES    10'h002
`define CFM_PSF_PIXELS   7'h10
`define CFM_BYP_LINES    10'h239
`define CFM_DIFF_MAX     32'h0000ffff
`define CFM_FIFO_DEPTH   16
`define CFM_PIX_W        10
`endif

// file: logic/cfm_pkg.sv
// Types shared by the cadence, freeze and motion control block
package cfm_pkg;
    typedef enum logic [1:0]
    {
        VB_ACTIVE = 2'h0,
        VB_FIRST  = 2'h1,
        VB_REST   = 2'h3
    } vblank_type;
    typedef enum logic [1:0]
    {
        FM_MANUAL = 2'h0,
        FM_AUTO   = 2'h1,
        FM_OFF    = 2'h2,
        FM_RSVD   = 2'h3
    } freeze_mode_type;
    typedef enum logic [1:0]
    {
        PM_DEINT  = 2'h0,
        PM_PSF    = 2'h1,
        PM_FILM   = 2'h2,
        PM_BYPASS = 2'h3
    } proc_mode_type;
endpackage : cfm_pkg

// file: logic/cfm_fifo.sv
// Parameterised valid/ready FIFO for the pixel path
module cfm_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Honest flags straight from the count
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = mem[rdPtr];

    // Storage, written only on an accepted push
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wrPtr <= AW'(wrPtr + 1'b1);
            if (pop)
                rdPtr <= AW'(rdPtr + 1'b1);
            if (push && !pop)
                count <= (AW+1)'(count + 1'b1);
            else if (pop && !push)
                count <= (AW+1)'(count - 1'b1);
        end
    end
endmodule : cfm_fifo

// file: logic/cadence_freeze_motion_control.sv
// Cadence lock, freeze-frame and motion mode control with APB registers
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "cfm_regs.svh"
module cadence_freeze_motion_control (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 fieldIn,
    input  wire logic                 vBlankIn,
    input  wire logic                 hSyncIn,
    input  wire logic                 freeze_comp_pin,
    input  wire logic [9:0]           pixIn,
    input  wire logic                 pixInValid,
    output logic                      pixInReady,
    output logic      [9:0]           pixOut,
    output logic                      pixOutValid,
    input  wire logic                 pixOutReady,
    output logic                      twoTwoLock,
    output logic                      freeze_detected,
    output logic                      freezeCompActive,
    output logic                      vertFilterEn,
    output logic                      motionEn,
    output cfm_pkg::proc_mode_type    procMode,
    output logic      [1:0]           latFields,
    output logic      [9:0]           latLines,
    output logic      [6:0]           latPixels
);
    import cfm_pkg::*;

    logic [`CFM_CTRL_W-1:0] ctrl;
    logic [15:0]            static_threshold_param;
    logic [15:0]            vert_freeze_param;
    freeze_mode_type        freeze_mode_sel;
    logic [1:0]             motion_mode_sel;
    logic                   freeze_comp_ctl;
    logic                   wrEn;
    logic                   rdEn;
    logic                   mapped;
    vblank_type             vbState;
    logic                   vBlankPrev;
    logic                   hSyncPrev;
    logic                   firstLineEnd;
    logic                   fieldStart;
    logic                   lastField;
    logic [2:0]             altCount;
    logic                   pixTake;
    logic [31:0]            fieldSum;
    logic [31:0]            sumPrev;
    logic [31:0]            sumPrev2;
    logic [31:0]            diffRaw;
    logic [15:0]            diffSat;
    logic                   frozen;
    logic [1:0]             latFieldsNext;
    logic [9:0]             latLinesNext;
    logic [6:0]             latPixelsNext;

    assign freeze_mode_sel = freeze_mode_type'(ctrl[`CFM_FMODE_HI:`CFM_FMODE_LO]);
    assign motion_mode_sel = ctrl[`CFM_MMODE_HI:`CFM_MMODE_LO];
    assign freeze_comp_ctl = ctrl[`CFM_FCTL_BIT];
    assign procMode = proc_mode_type'(ctrl[`CFM_PMODE_HI:`CFM_PMODE_LO]);

    // APB decode; zero wait states so every access ends in its access phase
    assign pready = 1'b1;
    assign mapped = (paddr == `CFM_CTRL_ADDR) || (paddr == `CFM_STATUS_ADDR)
                 || (paddr == `CFM_STATIC_ADDR) || (paddr == `CFM_VERT_ADDR);
    assign pslverr = psel & penable & ~mapped;
    assign wrEn = psel & penable & pwrite & mapped;
    assign rdEn = psel & ~penable & ~pwrite;

    // Writable registers; status is read-only and writes to it are dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl                   <= `CFM_CTRL_RST;
            static_threshold_param <= `CFM_PARAM_RST;
            vert_freeze_param      <= `CFM_PARAM_RST;
        end
        else if (wrEn)
        begin
            case (paddr)
                `CFM_CTRL_ADDR:   ctrl <= pwdata[`CFM_CTRL_W-1:0];
                `CFM_STATIC_ADDR: static_threshold_param <= pwdata[15:0];
                `CFM_VERT_ADDR:   vert_freeze_param <= pwdata[15:0];
                default:          ;
            endcase
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= '0;
        else if (rdEn)
        begin
            case (paddr)
                `CFM_CTRL_ADDR:   prdata <= {25'h0, ctrl};
                `CFM_STATUS_ADDR: prdata <= {28'h0, motionEn,
                                             freezeCompActive,
                                             freeze_detected, twoTwoLock};
                `CFM_STATIC_ADDR: prdata <= {16'h0, static_threshold_param};
                `CFM_VERT_ADDR:   prdata <= {16'h0, vert_freeze_param};
                default:          prdata <= '0;
            endcase
        end
    end

    // Edge detection of the timing inputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vBlankPrev <= 1'b0;
            hSyncPrev  <= 1'b0;
        end
        else
        begin
            vBlankPrev <= vBlankIn;
            hSyncPrev  <= hSyncIn;
        end
    end
    assign fieldStart = vBlankPrev & ~vBlankIn;
    assign firstLineEnd = (vbState == VB_FIRST) & hSyncIn & ~hSyncPrev;

    // Tracks where the first line of vertical blanking ends
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vbState <= VB_ACTIVE;
        else
        begin
            case (vbState)
                VB_ACTIVE: if (vBlankIn && !vBlankPrev) vbState <= VB_FIRST;
                VB_FIRST:  if (!vBlankIn) vbState <= VB_ACTIVE;
                           else if (firstLineEnd) vbState <= VB_REST;
                VB_REST:   if (!vBlankIn) vbState <= VB_ACTIVE;
                default:   vbState <= VB_ACTIVE;
            endcase
        end
    end

    // 2:2 cadence: fieldIn must alternate for several fields in a row
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lastField  <= 1'b0;
            altCount   <= '0;
            twoTwoLock <= 1'b0;
        end
        else if (firstLineEnd)
        begin
            lastField <= fieldIn;
            if (fieldIn != lastField)
            begin
                if (altCount != `CFM_LOCK_FIELDS)
                    altCount <= 3'(altCount + 1'b1);
                twoTwoLock <= (altCount >= 3'(`CFM_LOCK_FIELDS - 3'h1));
            end
            else
            begin
                altCount   <= '0;
                twoTwoLock <= 1'b0;
            end
        end
    end

    // Pixel path through the buffer; a full buffer stalls the source
    cfm_fifo #(
        .WIDTH    (`CFM_PIX_W),
        .DEPTH    (`CFM_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inData   (pixIn),
        .inValid  (pixInValid),
        .inReady  (pixInReady),
        .outData  (pixOut),
        .outValid (pixOutValid),
        .outReady (pixOutReady)
    );
    assign pixTake = pixInValid & pixInReady & ~vBlankIn;

    // Field signatures; adjacent fields of opposite parity are compared one field apart
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fieldSum <= '0;
            sumPrev  <= '0;
            sumPrev2 <= '0;
        end
        else if (fieldStart)
        begin
            fieldSum <= '0;
            sumPrev  <= fieldSum;
            sumPrev2 <= sumPrev;
        end
        else if (pixTake)
            fieldSum <= fieldSum + {22'h0, pixIn};
    end
    assign diffRaw = (sumPrev > sumPrev2) ? sumPrev - sumPrev2
                                          : sumPrev2 - sumPrev;
    assign diffSat = (diffRaw > `CFM_DIFF_MAX) ? 16'hffff : diffRaw[15:0];
    assign frozen = (diffSat <= static_threshold_param);

    // Freeze flag changes only at field start and holds for the field
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            freeze_detected <= 1'b0;
        else if (fieldStart)
            freeze_detected <= (freeze_mode_sel == FM_AUTO) & frozen;
    end

    // Mode decode; the reserved freeze code turns compensation and the vertical filter off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freezeCompActive <= 1'b0;
            vertFilterEn     <= 1'b0;
            motionEn         <= 1'b0;
        end
        else
        begin
            case (freeze_mode_sel)
                FM_AUTO:   freezeCompActive <= freeze_detected;
                FM_MANUAL: freezeCompActive <= freeze_comp_ctl &
                                               ~freeze_comp_pin;
                FM_OFF:    freezeCompActive <= 1'b0;
                default:   freezeCompActive <= 1'b0;
            endcase
            // Vertical filter joins from the static threshold up; inclusive
            // so a zero threshold forces it on even for a still picture
            vertFilterEn <= (freeze_mode_sel != FM_OFF) &&
                            (freeze_mode_sel != FM_RSVD) &&
                            (diffSat >= static_threshold_param) &&
                            (diffSat <= vert_freeze_param);
            motionEn <= (motion_mode_sel == 2'h1);
        end
    end

    // Fixed latency per processing mode, never per format
    always_comb
    begin
        case (procMode)
            PM_DEINT:
            begin
                latFieldsNext = `CFM_DI_FIELDS;
                latLinesNext  = `CFM_DI_LINES;
                latPixelsNext = `CFM_DI_PIXELS;
            end
            PM_FILM:
            begin
                latFieldsNext = `CFM_FILM_FIELDS;
                latLinesNext  = `CFM_FILM_LINES;
                latPixelsNext = `CFM_FILM_PIXELS;
            end
            PM_PSF:
            begin
                latFieldsNext = `CFM_PSF_FIELDS;
                latLinesNext  = `CFM_PSF_LINES;
                latPixelsNext = `CFM_PSF_PIXELS;
            end
            default:
            begin
                latFieldsNext = 2'h0;
                latLinesNext  = `CFM_BYP_LINES;
                latPixelsNext = 7'h00;
            end
        endcase
    end

    // Latency report registered for a clean data output
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latFields <= '0;
            latLines  <= '0;
            latPixels <= '0;
        end
        else
        begin
            latFields <= latFieldsNext;
            latLines  <= latLinesNext;
            latPixels <= latPixelsNext;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    lock_update_a: assert property ($changed(twoTwoLock) |->
        $past(firstLineEnd)) else $error("lock moved off first line");
    lock_field_a: assert property (firstLineEnd && fieldIn == lastField
        |=> !twoTwoLock) else $error("lock kept without alternation");
    freeze_off_a: assert property (freeze_mode_sel == FM_OFF
        [*2] |-> !freezeCompActive) else $error("comp on while off");
    freeze_auto_a: assert property (freeze_mode_sel == FM_AUTO |=>
        freezeCompActive == $past(freeze_detected))
        else $error("auto comp mismatch");
    detect_hold_a: assert property ($changed(freeze_detected) |->
        $past(fieldStart)) else $error("freeze flag moved mid field");
    manual_comp_a: assert property (freeze_mode_sel == FM_MANUAL |=>
        freezeCompActive == ($past(freeze_comp_ctl) &
        !$past(freeze_comp_pin))) else $error("manual comp wrong");
    motion_off_a: assert property (motion_mode_sel != 2'h1 |=> !motionEn)
        else $error("motion on while disabled");
    motion_on_a: assert property (motion_mode_sel == 2'h1 |=> motionEn)
        else $error("motion off in auto");
    deint_lat_a: assert property ((rst_n && procMode == PM_DEINT) [*2] |->
        latFields == 2'h1 && latLines == 10'h006 && latPixels == 7'h5b)
        else $error("deinterlace latency wrong");
    film_lat_a: assert property ((rst_n && procMode == PM_FILM) [*2] |->
        latFields == 2'h2 && latLines == 10'h004 && latPixels == 7'h08)
        else $error("film latency wrong");
    bypass_lat_a: assert property ((rst_n && procMode == PM_BYPASS) [*2] |->
        latLines == 10'h239) else $error("bypass latency wrong");
endmodule : cadence_freeze_motion_control

// file: tb/video_source.sv
// Interlaced video source model driving timing and pixel inputs
module video_source
(
    input  wire logic       clk,
    input  wire logic       pixInReady,
    output logic            fieldIn,
    output logic            vBlankIn,
    output logic            hSyncIn,
    output logic [9:0]      pixIn,
    output logic            pixInValid
);
    timeunit 1ns;
    timeprecision 100ps;

    // Start in blanking, no word offered
    initial
    begin
        fieldIn = 1'b0;
        vBlankIn = 1'b1;
        hSyncIn = 1'b0;
        pixIn = 10'h000;
        pixInValid = 1'b0;
    end

    // Word held until taken; bounded so a stuck sink cannot hang us
    task automatic push(input logic [9:0] v, output bit ok);
        int n;
        pixIn <= v;
        pixInValid <= 1'b1;
        n = 0;
        ok = 0;
        while (!ok && n < 40)
        begin
            @(posedge clk);
            ok = pixInReady;
            n++;
        end
    endtask : push

    task automatic idle();
        pixInValid <= 1'b0;
    endtask : idle

    // One line end in blanking with the field level set up
    task automatic line_mark(input logic f);
        fieldIn <= f;
        hSyncIn <= 1'b1;
        @(posedge clk);
        hSyncIn <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : line_mark

    // Blanking, then 64 active words; later blank lines carry a decoy level
    task automatic send_field(input logic f, input logic [9:0] base);
        bit ok;
        vBlankIn <= 1'b1;
        repeat (3) @(posedge clk);
        line_mark(f);
        line_mark(~f);
        fieldIn <= f;
        vBlankIn <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 64; i++)
            push(base + 10'(i), ok);
        pixInValid <= 1'b0;
    endtask : send_field
endmodule : video_source

// file: tb/tb_top.sv
// Self-checking bench for the cadence, freeze and motion control block
`include "cfm_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cfm_pkg::*;

    localparam int CAP = 20000;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          fieldIn;
    logic          vBlankIn;
    logic          hSyncIn;
    logic          freeze_comp_pin = 1'b0;
    logic [9:0]    pixIn;
    logic          pixInValid;
    logic          pixInReady;
    logic [9:0]    pixOut;
    logic          pixOutValid;
    logic          pixOutReady = 1'b0;
    logic          twoTwoLock;
    logic          freeze_detected;
    logic          freezeCompActive;
    logic          vertFilterEn;
    logic          motionEn;
    proc_mode_type procMode;
    logic [1:0]    latFields;
    logic [9:0]    latLines;
    logic [6:0]    latPixels;
    logic [1:0]    outCtl = 2'h1;
    logic [15:0]   rnd = 16'h5e97;
    logic [31:0]   rdata;
    logic          rerr;
    int            mismatches = 0;
    int            num_checks = 0;
    int            cycles = 0;

    always #2.5 clk = ~clk;

    cadence_freeze_motion_control cadence_freeze_motion_control_i
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fieldIn(fieldIn),
        .vBlankIn(vBlankIn), .hSyncIn(hSyncIn),
        .freeze_comp_pin(freeze_comp_pin), .pixIn(pixIn),
        .pixInValid(pixInValid), .pixInReady(pixInReady),
        .pixOut(pixOut), .pixOutValid(pixOutValid),
        .pixOutReady(pixOutReady), .twoTwoLock(twoTwoLock),
        .freeze_detected(freeze_detected),
        .freezeCompActive(freezeCompActive), .vertFilterEn(vertFilterEn),
        .motionEn(motionEn), .procMode(procMode), .latFields(latFields),
        .latLines(latLines), .latPixels(latPixels)
    );

    video_source video_source_i
    (
        .clk(clk), .pixInReady(pixInReady), .fieldIn(fieldIn),
        .vBlankIn(vBlankIn), .hSyncIn(hSyncIn), .pixIn(pixIn),
        .pixInValid(pixInValid)
    );

    function automatic logic [15:0] next_rnd();
        rnd ^= rnd << 7;
        rnd ^= rnd >> 9;
        rnd ^= rnd << 8;
        return rnd;
    endfunction : next_rnd

    function automatic logic [31:0] ctrl(input logic [1:0] fm,
        input logic [1:0] mm, input logic [1:0] pm, input logic ctl);
        logic [31:0] w;
        w = 32'h0;
        w[`CFM_FMODE_HI:`CFM_FMODE_LO] = fm;
        w[`CFM_MMODE_HI:`CFM_MMODE_LO] = mm;
        w[`CFM_PMODE_HI:`CFM_PMODE_LO] = pm;
        w[`CFM_FCTL_BIT] = ctl;
        return w;
    endfunction : ctrl

    // Latency as fields, lines, pixels; film counts a frame as 2 fields
    function automatic logic [18:0] exp_lat(input logic [1:0] p);
        case (p)
            2'h0: return {2'h1, 10'h006, 7'h5b};
            2'h1: return {2'h1, 10'h002, 7'h10};
            default: return {2'h2, 10'h004, 7'h08};
        endcase
    endfunction : exp_lat

    // Pin high in manual mode is taken as compensation off
    function automatic logic exp_comp(input logic [1:0] m,
        input logic ctl, input logic pin);
        return (m == 2'h0) && ctl && !pin;
    endfunction : exp_comp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // One APB transfer; waits for pready, the hang guard ends a stuck wait
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // Far side stalls at random unless a test pins it
    always @(posedge clk)
        pixOutReady <= (outCtl == 2'h2)
            || (outCtl == 2'h0 && (next_rnd() & 16'h1) != 16'h0);

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == CAP)
        begin
            mismatches++;
            complete_run();
        end
    end

    initial
    begin
        logic [9:0]  base;
        logic [31:0] v;
        bit          ok;
        int          took;
        int          n;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `CFM_CTRL_ADDR, 32'h0);
        chk(rdata, 32'h2);
        chk({latFields, latLines, latPixels}, exp_lat(2'h0));
        // Latency per processing mode, bypass reports lines only
        for (int p = 0; p < 4; p++)
        begin
            apb(1'b1, `CFM_CTRL_ADDR, ctrl(2'h2, 2'h0, 2'(p), 1'b0));
            repeat (2) @(posedge clk);
            chk(procMode, 32'(p));
            if (p == 3)
                chk(latLines, 32'h239);
            else
                chk({latFields, latLines, latPixels}, exp_lat(2'(p)));
        end
        // Every motion code, and each freeze code but auto, against pin and control bit
        for (int k = 0; k < 16; k++)
        begin
            freeze_comp_pin <= k[0];
            apb(1'b1, `CFM_CTRL_ADDR, ctrl(k[3:2], k[3:2], 2'h0, k[1]));
            repeat (3) @(posedge clk);
            apb(1'b0, `CFM_STATUS_ADDR, 32'h0);
            chk(motionEn, 32'(k[3:2] == 2'h1));
            chk(rdata[3], 32'(k[3:2] == 2'h1));
            if (k[3:2] != 2'h1)
                chk(freezeCompActive, exp_comp(k[3:2], k[1], k[0]));
        end
        repeat (4)
        begin
            v = {next_rnd(), next_rnd()};
            apb(1'b1, `CFM_VERT_ADDR, v);
            apb(1'b0, `CFM_VERT_ADDR, 32'h0);
            chk(rdata, {16'h0, v[15:0]});
        end
        apb(1'b0, 8'h10, 32'h0);
        chk(rerr, 32'h1);
        chk(rdata, 32'h0);
        // Fill with output stalled until refused, then drain in order
        base = 10'(next_rnd());
        took = 0;
        ok = 1;
        while (ok && took < 20)
        begin
            video_source_i.push(base + 10'(took), ok);
            if (ok)
                took++;
        end
        video_source_i.idle();
        chk(took, 32'h10);
        outCtl <= 2'h2;
        for (int i = 0; i < 16; i++)
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (!(pixOutValid === 1'b1 && pixOutReady === 1'b1)
                && n < 20);
            chk(pixOut, base + 10'(i));
        end
        // Automatic freeze with the pin high; still fields alternate
        outCtl <= 2'h0;
        apb(1'b1, `CFM_STATIC_ADDR, 32'h0);
        apb(1'b1, `CFM_CTRL_ADDR, ctrl(2'h1, 2'h1, 2'h0, 1'b0));
        freeze_comp_pin <= 1'b1;
        base = 10'(next_rnd());
        for (int i = 0; i < 6; i++)
            video_source_i.send_field(i[0], base);
        chk(twoTwoLock, 32'h1);
        chk(freeze_detected, 32'h1);
        chk(freezeCompActive, 32'h1);
        video_source_i.send_field(1'b1, base ^ 10'h2aa);
        chk(twoTwoLock, 32'h0);
        video_source_i.send_field(1'b0, base ^ 10'h155);
        // Flag looks back over older field sums, so one more field clears it
        video_source_i.send_field(1'b1, base);
        chk(freeze_detected, 32'h0);
        chk(freezeCompActive, 32'h0);
        // Forced vertical filter with no freeze in motion, then forced freeze in static
        freeze_comp_pin <= 1'b0;
        apb(1'b1, `CFM_VERT_ADDR, 32'hffff);
        apb(1'b1, `CFM_CTRL_ADDR, ctrl(2'h0, 2'h1, 2'h0, 1'b0));
        repeat (3) @(posedge clk);
        chk(vertFilterEn, 32'h1);
        chk(freezeCompActive, 32'h0);
        apb(1'b1, `CFM_STATIC_ADDR, 32'h7fff);
        apb(1'b1, `CFM_VERT_ADDR, 32'h0);
        apb(1'b1, `CFM_CTRL_ADDR, ctrl(2'h0, 2'h1, 2'h0, 1'b1));
        repeat (3) @(posedge clk);
        chk(vertFilterEn, 32'h0);
        chk(freezeCompActive, 32'h1);
        // Second reset mid-run clears freezeCompActive and returns control to its reset value 2
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(freezeCompActive, 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, `CFM_CTRL_ADDR, 32'h0);
        chk(rdata, 32'h2);
        complete_run();
    end
endmodule : tb_top
